// ### testbench/cpm_exec_model.sv
// exec-side stand-in that issues one op per call into the register set
// assumes one caller at a time; every change lands just after a rising edge of clk_i
`timescale 1ns/1ps
`default_nettype none
module cpm_exec_model (
    input wire logic clk_i, // bus clock
    output logic valid_o, // op strobe
    output cpm_pkg::cpm_op_e op_o, // op code
    output logic lo_o, // exchange low part
    output cpm_pkg::cpm_byte_t opnd_o, // operand or offset
    output logic bit_o, // tested memory bit
    output cpm_pkg::cpm_addr_t tgt_o // absolute target
);
    import cpm_pkg::*;
    initial begin
        valid_o = 1'b0;
        op_o = CPM_OP_NOP;
        lo_o = 1'b0;
        opnd_o = 8'h00;
        bit_o = 1'b0;
        tgt_o = 14'h0000;
    end
    // gap idles first, so prompt and slow issue both occur
    task automatic issue(input cpm_op_e op, input cpm_byte_t opnd, input cpm_addr_t tgt, input logic b,
            input logic lo, input int gap);
        repeat (gap) @(posedge clk_i);
        @(posedge clk_i);
        valid_o <= 1'b1;
        op_o <= op;
        opnd_o <= opnd;
        tgt_o <= tgt;
        bit_o <= b;
        lo_o <= lo;
        @(posedge clk_i);
        valid_o <= 1'b0;
        // operand and bit are stale once the strobe drops
        opnd_o <= ~opnd;
        bit_o <= ~b;
        @(negedge clk_i);
    endtask
endmodule // cpm_exec_model
`default_nettype wire

// ### testbench/tb_cpu_programmer_model_regs.sv
// self-checking bench for the processor register set
// assumes cpm_exec_model on the exec port; the Wishbone master lives in tasks here
`timescale 1ns/1ps
`default_nettype none
module tb_cpu_programmer_model_regs;
    import cpm_pkg::*;
    typedef struct packed {cpm_op_e op; cpm_byte_t opnd; cpm_byte_t acc; logic [1:0] zc;} cpm_alu_s;
    typedef struct packed {cpm_op_e op; cpm_byte_t opnd; cpm_addr_t tgt; logic b; logic lo; cpm_byte_t acc;
        cpm_addr_t pc; cpm_addr_t rtn; logic c; logic tk;} cpm_flow_s;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic fetch = 1'b0;
    logic [10:0] adr = 11'h000;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] rdat;
    logic ack, valid, lo, tbit, fz, fc, taken;
    cpm_op_e op;
    cpm_byte_t opnd, acc, result;
    cpm_addr_t tgt, phys, pc, rtn;
    cpm_addr_t core = 14'h0000;
    int err_count = 0;
    int samples_checked = 0;
    cpm_alu_s alu_tab [25] = '{
        '{CPM_OP_LOAD, 8'h80, 8'h80, 2'b00}, '{CPM_OP_ADD, 8'h80, 8'h00, 2'b11},
        '{CPM_OP_LOAD, 8'h7F, 8'h7F, 2'b01}, '{CPM_OP_ADD, 8'h90, 8'h0F, 2'b01},
        '{CPM_OP_LOAD, 8'h90, 8'h90, 2'b01}, '{CPM_OP_ADD, 8'h10, 8'hA0, 2'b00},
        '{CPM_OP_SUB, 8'h20, 8'h80, 2'b00}, '{CPM_OP_SUB, 8'h81, 8'hFF, 2'b01},
        '{CPM_OP_CMP, 8'hFF, 8'hFF, 2'b10}, '{CPM_OP_SETC, 8'h00, 8'hFF, 2'b11},
        '{CPM_OP_AND, 8'h0F, 8'h0F, 2'b01}, '{CPM_OP_XOR, 8'h0F, 8'h00, 2'b11},
        '{CPM_OP_OR, 8'h3C, 8'h3C, 2'b01}, '{CPM_OP_INC, 8'h00, 8'h3D, 2'b01},
        '{CPM_OP_CLRC, 8'h00, 8'h3D, 2'b00}, '{CPM_OP_CLR, 8'h00, 8'h00, 2'b10},
        '{CPM_OP_LOAD, 8'h81, 8'h81, 2'b00}, '{CPM_OP_LSL, 8'h00, 8'h02, 2'b01},
        '{CPM_OP_ROL, 8'h00, 8'h05, 2'b00}, '{CPM_OP_ROR, 8'h00, 8'h02, 2'b01},
        '{CPM_OP_LSR, 8'h00, 8'h01, 2'b00}, '{CPM_OP_MOVE, 8'h00, 8'h01, 2'b10},
        '{CPM_OP_LOAD, 8'h2A, 8'h2A, 2'b00}, '{CPM_OP_STORE, 8'h00, 8'h2A, 2'b00},
        '{CPM_OP_SETC, 8'h00, 8'h2A, 2'b01}};
    cpm_flow_s flow_tab [13] = '{
        '{CPM_OP_JUMP, 8'h00, 14'h0100, 1'b0, 1'b0, 8'h2A, 14'h0100, 14'h3FFD, 1'b1, 1'b1},
        '{CPM_OP_BR_ZC, 8'h10, 14'h0000, 1'b0, 1'b0, 8'h2A, 14'h0110, 14'h3FFD, 1'b1, 1'b1},
        '{CPM_OP_BR_ZS, 8'h10, 14'h0000, 1'b0, 1'b0, 8'h2A, 14'h0110, 14'h3FFD, 1'b1, 1'b0},
        '{CPM_OP_BR_CS, 8'hF0, 14'h0000, 1'b0, 1'b0, 8'h2A, 14'h0100, 14'h3FFD, 1'b1, 1'b1},
        '{CPM_OP_BR_CC, 8'h05, 14'h0000, 1'b0, 1'b0, 8'h2A, 14'h0100, 14'h3FFD, 1'b1, 1'b0},
        '{CPM_OP_BIT_LOW, 8'h08, 14'h0000, 1'b0, 1'b0, 8'h2A, 14'h0108, 14'h3FFD, 1'b0, 1'b1},
        '{CPM_OP_BR_AE, 8'h04, 14'h0000, 1'b0, 1'b0, 8'h2A, 14'h010C, 14'h3FFD, 1'b0, 1'b1},
        '{CPM_OP_BIT_HIGH, 8'h04, 14'h0000, 1'b1, 1'b0, 8'h2A, 14'h0110, 14'h3FFD, 1'b1, 1'b1},
        '{CPM_OP_CALL_ABS, 8'h00, 14'h0200, 1'b0, 1'b0, 8'h2A, 14'h0200, 14'h0110, 1'b1, 1'b1},
        '{CPM_OP_RETURN, 8'h00, 14'h0000, 1'b0, 1'b0, 8'h2A, 14'h0110, 14'h0110, 1'b1, 1'b1},
        '{CPM_OP_CALL_REL, 8'h20, 14'h0000, 1'b0, 1'b0, 8'h2A, 14'h0130, 14'h0110, 1'b1, 1'b1},
        '{CPM_OP_XCH_HI, 8'h00, 14'h0000, 1'b0, 1'b0, 8'h01, 14'h0130, 14'h2A10, 1'b1, 1'b0},
        '{CPM_OP_XCH_HI, 8'h00, 14'h0000, 1'b0, 1'b1, 8'h10, 14'h0130, 14'h2A01, 1'b1, 1'b0}};

    always #10 clk = ~clk;

    cpm_regs dut (.MCLK_I(clk), .RESET_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .FETCH_I(fetch),
        .EXEC_VALID_I(valid), .EXEC_OP_I(op), .EXEC_XCH_LO_I(lo), .EXEC_OPND_I(opnd), .EXEC_BIT_I(tbit),
        .EXEC_TARGET_I(tgt), .CORE_ADDR_I(core), .PHYS_ADDR_O(phys), .ACC_O(acc), .PC_O(pc), .RTN_O(rtn),
        .FLAG_Z_O(fz), .FLAG_C_O(fc), .RESULT_O(result), .TAKEN_O(taken));
    cpm_exec_model seq (.clk_i(clk), .valid_o(valid), .op_o(op), .lo_o(lo), .opnd_o(opnd), .bit_o(tbit),
        .tgt_o(tgt));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // classic single cycle: hold everything until ack is sampled high
    task automatic wb(input logic w, input logic [10:0] a, input logic [7:0] d, output logic [31:0] q);
        int n;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'h1;
        wdat <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        chk("wb ack wait", 32'h2, n);
    endtask
    task automatic wr(input logic [10:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    task automatic rd(input string what, input logic [10:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 8'h00, q);
        chk(what, exp, q);
    endtask
    task automatic xl(input cpm_addr_t a, input cpm_addr_t exp);
        @(posedge clk);
        core <= a;
        @(posedge clk);
        @(negedge clk);
        chk("phys", exp, phys);
    endtask

    task automatic t_reset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        @(negedge clk);
        chk("acc", 8'h00, acc);
        chk("pc", 14'h3FFD, pc);
        chk("rtn", 14'h3FFD, rtn);
        chk("z c", 2'b00, {fz, fc});
        @(posedge clk);
        rst_n <= 1'b1;
        rd("debug flags", 11'h400, 32'h0);
    endtask
    task automatic t_fetch;
        @(posedge clk);
        fetch <= 1'b1;
        repeat (3) @(posedge clk);
        fetch <= 1'b0;
        @(negedge clk);
        chk("pc wrap", 14'h0000, pc);
    endtask
    task automatic t_regs;
        wr(11'h07C, 8'h12);
        rd("page_select", 11'h07C, 32'h12);
        wr(11'h03C, 8'h10);
        rd("index_pointer", 11'h03C, 32'h10);
        wr(11'h040, 8'h5A);
        rd("window read", 11'h038, 32'h5A);
        wr(11'h038, 8'hA5);
        rd("window write", 11'h040, 32'hA5);
        wr(11'h314, 8'h77);
        rd("unmapped", 11'h314, 32'h00);
        xl(14'h000E, 14'h0010);
        xl(14'h00C5, 14'h0485);
        xl(14'h00FF, 14'h04BF);
        xl(14'h0030, 14'h0030);
        wr(11'h03C, 8'h1F);
        rd("window page", 11'h038, 32'h12);
    endtask
    task automatic t_alu;
        foreach (alu_tab[i]) begin
            seq.issue(alu_tab[i].op, alu_tab[i].opnd, 14'h0000, 1'b0, 1'b0, i % 3);
            chk("acc", alu_tab[i].acc, acc);
            chk("z c", alu_tab[i].zc, {fz, fc});
        end
        chk("result", 8'h2A, result);
    endtask
    task automatic t_flow;
        foreach (flow_tab[i]) begin
            seq.issue(flow_tab[i].op, flow_tab[i].opnd, flow_tab[i].tgt, flow_tab[i].b, flow_tab[i].lo, i % 2);
            chk("acc", flow_tab[i].acc, acc);
            chk("pc", flow_tab[i].pc, pc);
            chk("rtn", flow_tab[i].rtn, rtn);
            chk("carry", flow_tab[i].c, fc);
            chk("taken", flow_tab[i].tk, taken);
        end
    endtask
    task automatic t_debug;
        wr(11'h400, 8'h02);
        @(negedge clk);
        chk("z c", 2'b10, {fz, fc});
        rd("debug flags", 11'h400, 32'h2);
        rd("debug acc", 11'h404, 32'h10);
        seq.issue(CPM_OP_BR_ZS, 8'h04, 14'h0000, 1'b0, 1'b0, 0);
        chk("pc", 14'h0134, pc);
        seq.issue(CPM_OP_BR_CC, 8'h04, 14'h0000, 1'b0, 1'b0, 0);
        chk("pc", 14'h0138, pc);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        t_reset;
        t_fetch;
        t_regs;
        t_alu;
        t_flow;
        t_debug;
        t_reset;
        summarize;
    end
    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        $display("MISMATCH watchdog expected finish seen timeout");
        summarize;
    end
endmodule // tb_cpu_programmer_model_regs
`default_nettype wire

// ### verilog/cpm_params.svh
// constants for the processor register set: bus map, reset values, flag bits
// assumes inclusion by the register-set module only
`ifndef CPM_PARAMS_SVH
`define CPM_PARAMS_SVH

// register indices in the direct page; byte address is four times the index
`define CPM_IDX_DATA_WINDOW 8'h0E
`define CPM_IDX_INDEX_PTR 8'h0F
`define CPM_IDX_PAGE_SELECT 8'h1F
// page window bounds in the direct page
`define CPM_WIN_LO 8'hC0
`define CPM_WIN_HI 8'hFF
// debug bank indices, selected by address bit 10
`define CPM_DBG_FLAGS 8'h00
`define CPM_DBG_ACC 8'h01
`define CPM_DBG_PC 8'h02
`define CPM_DBG_RTN 8'h03
`define CPM_BANK_BIT 10
// flag bit positions in the debug flag register
`define CPM_FLAG_C_BIT 0
`define CPM_FLAG_Z_BIT 1
// reset values
`define CPM_ACC_RST 8'h00
`define CPM_PC_RST 14'h3FFD
`define CPM_RTN_RST 14'h3FFD
`define CPM_FLAG_RST 1'b0
`define CPM_REG_RST 8'h00

`endif

// ### verilog/cpm_pkg.sv
// types shared by the processor register set and its execution partner
// assumes cpm_params.svh is on the include path
package cpm_pkg;
    typedef enum logic [4:0] {
        CPM_OP_NOP, CPM_OP_LOAD, CPM_OP_STORE, CPM_OP_MOVE,
        CPM_OP_ADD, CPM_OP_SUB, CPM_OP_CMP, CPM_OP_AND, CPM_OP_OR, CPM_OP_XOR,
        CPM_OP_INC, CPM_OP_DEC, CPM_OP_CLR,
        CPM_OP_LSL, CPM_OP_LSR, CPM_OP_ROL, CPM_OP_ROR,
        CPM_OP_SETC, CPM_OP_CLRC, CPM_OP_BIT_HIGH, CPM_OP_BIT_LOW,
        CPM_OP_BR_ZS, CPM_OP_BR_ZC, CPM_OP_BR_CC, CPM_OP_BR_CS, CPM_OP_BR_AE, CPM_OP_BRA,
        CPM_OP_JUMP, CPM_OP_CALL_ABS, CPM_OP_CALL_REL, CPM_OP_RETURN,
        CPM_OP_XCH_HI
    } cpm_op_e;
    // exchange with low return byte shares the code of the last entry, CPM_OP_XCH_HI, selected by EXEC_XCH_LO_I
    typedef logic [13:0] cpm_addr_t;
    typedef logic [7:0] cpm_byte_t;
endpackage

// ### verilog/cpm_regs.sv
// processor register set: accumulator, program counter, return counter, flags,
// index pointer, page select and data-address translation, on a Wishbone slave
// assumes a sequencer drives one op per EXEC_VALID_I pulse, synchronous inputs
`timescale 1ns/1ps
`default_nettype none
`include "cpm_params.svh"

// Notes on behaviour
// - accumulator is 8 bits, cleared by reset
// - arithmetic and logic results are written back into the accumulator
// - program counter is 14 bits, steps by one per fetched byte
// - jumps, taken branches and returns load a non-sequential target
// - program counter resets to 3FFD
// - return counter is 14 bits, captures return address on either call
// - return copies the return counter into the program counter
// - return counter resets to 3FFD
// - exchange ops swap accumulator with high or low return counter part
// - two flag bits, branch-tested only, read and written by debug access
// - zero and carry flags clear on reset
// - data ops set zero flag exactly when the 8-bit result is 00
// - addition sets carry on unsigned overflow
// - subtract or compare sets carry when memory operand exceeds register
// - only add, subtract, compare, shifts, rotates, set, clear and bit tests change carry
// - bit-test branches copy the tested bit into carry
// - set and clear carry ops force carry, nothing else changes
// - shifts and rotates are 9-bit through carry
// - equal branches use zero only, carry branches use carry only
// - data window, index pointer, page select at 0E, 0F, 1F, 8 bits
// - data window accesses are redirected to the location in the pointer
// - page window C0 to FF reaches the whole 16K space via page select
// - direct addresses get six zero bits prefixed
// - relative branch adds sign-extended offset to program counter
module cpm_regs #(
    parameter int DP_DEPTH = 192
) (
    input wire logic MCLK_I, // bus clock
    input wire logic RESET_N_I, // async reset, active low
    input wire logic WB_CYC_I, // wishbone cycle
    input wire logic WB_STB_I, // wishbone strobe
    input wire logic WB_WE_I, // wishbone write
    input wire logic [10:0] WB_ADR_I, // byte address
    input wire logic [3:0] WB_SEL_I, // byte lanes
    input wire logic [31:0] WB_DAT_I, // write data
    output logic [31:0] WB_DAT_O, // read data
    output logic WB_ACK_O, // acknowledge
    input wire logic FETCH_I, // one byte fetched
    input wire logic EXEC_VALID_I, // op strobe
    input wire cpm_pkg::cpm_op_e EXEC_OP_I, // op code
    input wire logic EXEC_XCH_LO_I, // exchange low part instead of high
    input wire cpm_pkg::cpm_byte_t EXEC_OPND_I, // memory operand or offset
    input wire logic EXEC_BIT_I, // tested memory bit
    input wire cpm_pkg::cpm_addr_t EXEC_TARGET_I, // absolute target
    input wire cpm_pkg::cpm_addr_t CORE_ADDR_I, // logical data address
    output cpm_pkg::cpm_addr_t PHYS_ADDR_O, // translated data address
    output cpm_pkg::cpm_byte_t ACC_O, // accumulator
    output cpm_pkg::cpm_addr_t PC_O, // program counter
    output cpm_pkg::cpm_addr_t RTN_O, // return counter
    output logic FLAG_Z_O, // zero flag
    output logic FLAG_C_O, // carry flag
    output cpm_pkg::cpm_byte_t RESULT_O, // store or move data
    output logic TAKEN_O // last op changed flow
);
    import cpm_pkg::*;

    cpm_byte_t acc_r, acc_nxt;
    cpm_addr_t pc_r, pc_nxt;
    cpm_addr_t rtn_r, rtn_nxt;
    logic z_r, z_nxt, c_r, c_nxt;
    logic dbg_flag_wr;
    cpm_byte_t idx_r, page_r, result_r, result_nxt;
    logic taken_r, taken_nxt;
    cpm_addr_t phys_r;
    logic ack_r;
    logic [31:0] rdat_r;
    cpm_byte_t dp_mem [DP_DEPTH];

    function automatic cpm_addr_t rel_target(input cpm_addr_t pc, input cpm_byte_t off);
        rel_target = pc + {{6{off[7]}}, off};
    endfunction

    // direct-page, data-window and page-window translation
    function automatic cpm_addr_t xlate(input cpm_addr_t a, input cpm_byte_t ptr, input cpm_byte_t pg);
        if (a == {6'h00, `CPM_IDX_DATA_WINDOW}) begin
            xlate = {6'h00, ptr};
        end else if (a[13:8] == 6'h00 && a[7:0] >= `CPM_WIN_LO) begin
            xlate = {pg, a[5:0]};
        end else begin
            xlate = a;
        end
    endfunction

    // ---------------- execution datapath ----------------
    wire [8:0] sum9 = {1'b0, acc_r} + {1'b0, EXEC_OPND_I};
    wire [7:0] diff8 = acc_r - EXEC_OPND_I;
    wire add_carry = (acc_r[7] & EXEC_OPND_I[7]) | ((acc_r[7] | EXEC_OPND_I[7]) & ~sum9[7]);
    wire sub_borrow = EXEC_OPND_I > acc_r;
    wire cpm_addr_t br_dest = rel_target(pc_r, EXEC_OPND_I);
    wire cpm_addr_t pc_seq = pc_r + 14'h0001;

    always_comb begin
        acc_nxt = acc_r;
        pc_nxt = FETCH_I ? pc_seq : pc_r;
        rtn_nxt = rtn_r;
        z_nxt = z_r;
        c_nxt = c_r;
        result_nxt = result_r;
        taken_nxt = 1'b0;
        if (EXEC_VALID_I) begin
            case (EXEC_OP_I)
                CPM_OP_LOAD: begin
                    acc_nxt = EXEC_OPND_I;
                    z_nxt = EXEC_OPND_I == 8'h00;
                end
                CPM_OP_STORE: begin
                    result_nxt = acc_r;
                    z_nxt = acc_r == 8'h00;
                end
                CPM_OP_MOVE: begin
                    result_nxt = EXEC_OPND_I;
                    z_nxt = EXEC_OPND_I == 8'h00;
                end
                CPM_OP_ADD: begin
                    acc_nxt = sum9[7:0];
                    z_nxt = sum9[7:0] == 8'h00;
                    c_nxt = add_carry;
                end
                CPM_OP_SUB: begin
                    acc_nxt = diff8;
                    z_nxt = diff8 == 8'h00;
                    c_nxt = sub_borrow;
                end
                CPM_OP_CMP: begin
                    z_nxt = diff8 == 8'h00;
                    c_nxt = sub_borrow;
                end
                CPM_OP_AND: begin
                    acc_nxt = acc_r & EXEC_OPND_I;
                    z_nxt = (acc_r & EXEC_OPND_I) == 8'h00;
                end
                CPM_OP_OR: begin
                    acc_nxt = acc_r | EXEC_OPND_I;
                    z_nxt = (acc_r | EXEC_OPND_I) == 8'h00;
                end
                CPM_OP_XOR: begin
                    acc_nxt = acc_r ^ EXEC_OPND_I;
                    z_nxt = (acc_r ^ EXEC_OPND_I) == 8'h00;
                end
                CPM_OP_INC: begin
                    acc_nxt = acc_r + 8'h01;
                    z_nxt = acc_r == 8'hFF;
                end
                CPM_OP_DEC: begin
                    acc_nxt = acc_r - 8'h01;
                    z_nxt = acc_r == 8'h01;
                end
                CPM_OP_CLR: begin
                    acc_nxt = 8'h00;
                    z_nxt = 1'b1;
                end
                CPM_OP_LSL: begin
                    {c_nxt, acc_nxt} = {acc_r, 1'b0};
                    z_nxt = acc_r[6:0] == 7'h00;
                end
                CPM_OP_LSR: begin
                    {acc_nxt, c_nxt} = {1'b0, acc_r};
                    z_nxt = acc_r[7:1] == 7'h00;
                end
                CPM_OP_ROL: begin
                    {c_nxt, acc_nxt} = {acc_r, c_r};
                    z_nxt = {acc_r[6:0], c_r} == 8'h00;
                end
                CPM_OP_ROR: begin
                    {acc_nxt, c_nxt} = {c_r, acc_r};
                    z_nxt = {c_r, acc_r[7:1]} == 8'h00;
                end
                CPM_OP_SETC: c_nxt = 1'b1;
                CPM_OP_CLRC: c_nxt = 1'b0;
                CPM_OP_BIT_HIGH, CPM_OP_BIT_LOW: begin
                    c_nxt = EXEC_BIT_I;
                    taken_nxt = EXEC_BIT_I == (EXEC_OP_I == CPM_OP_BIT_HIGH);
                end
                CPM_OP_BR_ZS: taken_nxt = z_r;
                CPM_OP_BR_ZC: taken_nxt = ~z_r;
                CPM_OP_BR_CC, CPM_OP_BR_AE: taken_nxt = ~c_r;
                CPM_OP_BR_CS: taken_nxt = c_r;
                CPM_OP_BRA: taken_nxt = 1'b1;
                CPM_OP_JUMP: begin
                    pc_nxt = EXEC_TARGET_I;
                    taken_nxt = 1'b1;
                end
                CPM_OP_CALL_ABS: begin
                    rtn_nxt = pc_r;
                    pc_nxt = EXEC_TARGET_I;
                    taken_nxt = 1'b1;
                end
                CPM_OP_CALL_REL: begin
                    rtn_nxt = pc_r;
                    pc_nxt = br_dest;
                    taken_nxt = 1'b1;
                end
                CPM_OP_RETURN: begin
                    pc_nxt = rtn_r;
                    taken_nxt = 1'b1;
                end
                CPM_OP_XCH_HI: begin
                    if (EXEC_XCH_LO_I) begin
                        acc_nxt = rtn_r[7:0];
                        rtn_nxt = {rtn_r[13:8], acc_r};
                    end else begin
                        acc_nxt = {2'b00, rtn_r[13:8]};
                        rtn_nxt = {acc_r[5:0], rtn_r[7:0]};
                    end
                end
                default: ;
            endcase
            // taken relative branches replace the sequential value
            if (taken_nxt && EXEC_OP_I inside {CPM_OP_BIT_HIGH, CPM_OP_BIT_LOW, CPM_OP_BR_ZS, CPM_OP_BR_ZC,
                    CPM_OP_BR_CC, CPM_OP_BR_CS, CPM_OP_BR_AE, CPM_OP_BRA}) begin
                pc_nxt = br_dest;
            end
        end
        // debug write of the flags overrides the sequencer
        if (dbg_flag_wr) begin
            z_nxt = WB_DAT_I[`CPM_FLAG_Z_BIT];
            c_nxt = WB_DAT_I[`CPM_FLAG_C_BIT];
        end
    end

    // ---------------- wishbone decode ----------------
    wire bus_req = WB_CYC_I & WB_STB_I & ~ack_r;
    wire bank_dbg = WB_ADR_I[`CPM_BANK_BIT];
    wire [7:0] bus_idx = WB_ADR_I[9:2];
    wire wr_lane = bus_req & WB_WE_I & WB_SEL_I[0];
    // data window redirects the bus to the location named by the pointer
    wire [7:0] eff_idx = (bus_idx == `CPM_IDX_DATA_WINDOW) ? idx_r : bus_idx;
    wire hit_idx = ~bank_dbg & (eff_idx == `CPM_IDX_INDEX_PTR);
    wire hit_page = ~bank_dbg & (eff_idx == `CPM_IDX_PAGE_SELECT);
    wire hit_mem = ~bank_dbg & ~hit_idx & ~hit_page & (32'(eff_idx) < DP_DEPTH);
    assign dbg_flag_wr = wr_lane & bank_dbg & (bus_idx == `CPM_DBG_FLAGS);
    wire [31:0] dbg_rdata =
        (bus_idx == `CPM_DBG_FLAGS) ? 32'(c_r) | (32'(z_r) << `CPM_FLAG_Z_BIT) :
        (bus_idx == `CPM_DBG_ACC) ? 32'(acc_r) :
        (bus_idx == `CPM_DBG_PC) ? 32'(pc_r) :
        (bus_idx == `CPM_DBG_RTN) ? 32'(rtn_r) : 32'h0000_0000;
    wire [31:0] dp_rdata = hit_idx ? 32'(idx_r) : hit_page ? 32'(page_r) :
        hit_mem ? 32'(dp_mem[eff_idx]) : 32'h0000_0000;
    wire [31:0] rdata_nxt = bank_dbg ? dbg_rdata : dp_rdata;

    // ---------------- registers ----------------
    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            acc_r <= `CPM_ACC_RST;
            pc_r <= `CPM_PC_RST;
            rtn_r <= `CPM_RTN_RST;
            z_r <= `CPM_FLAG_RST;
            c_r <= `CPM_FLAG_RST;
            result_r <= `CPM_REG_RST;
            taken_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            pc_r <= pc_nxt;
            rtn_r <= rtn_nxt;
            z_r <= z_nxt;
            c_r <= c_nxt;
            result_r <= result_nxt;
            taken_r <= taken_nxt;
        end
    end

    always_ff @(posedge MCLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            idx_r <= `CPM_REG_RST;
            page_r <= `CPM_REG_RST;
            phys_r <= 14'h0000;
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
        end else begin
            if (wr_lane && hit_idx) idx_r <= WB_DAT_I[7:0];
            if (wr_lane && hit_page) page_r <= WB_DAT_I[7:0];
            phys_r <= xlate(CORE_ADDR_I, idx_r, page_r);
            ack_r <= bus_req;
            if (bus_req) rdat_r <= rdata_nxt;
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (wr_lane && hit_mem) dp_mem[eff_idx] <= WB_DAT_I[7:0];
    end

    assign WB_ACK_O = ack_r;
    assign WB_DAT_O = rdat_r;
    assign PHYS_ADDR_O = phys_r;
    assign ACC_O = acc_r;
    assign PC_O = pc_r;
    assign RTN_O = rtn_r;
    assign FLAG_Z_O = z_r;
    assign FLAG_C_O = c_r;
    assign RESULT_O = result_r;
    assign TAKEN_O = taken_r;

    // ---------------- assertions ----------------
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESET_N_I);

    wire plain_op = EXEC_VALID_I && !dbg_flag_wr;

    a_add_carry: assert property (plain_op && EXEC_OP_I == CPM_OP_ADD |=>
        c_r == ($past(acc_r) + {1'b0, $past(EXEC_OPND_I)} > 9'h0FF) && acc_r == 8'($past(sum9)))
        else $error("add carry or result wrong");
    a_sub_borrow: assert property (plain_op && EXEC_OP_I == CPM_OP_SUB |=>
        c_r == ($past(EXEC_OPND_I) > $past(acc_r)))
        else $error("subtract borrow wrong");
    a_zero_load: assert property (plain_op && EXEC_OP_I == CPM_OP_LOAD |=>
        acc_r == $past(EXEC_OPND_I) && z_r == ($past(EXEC_OPND_I) == 8'h00))
        else $error("zero flag after load wrong");
    a_carry_keep: assert property (plain_op && EXEC_OP_I inside {CPM_OP_AND, CPM_OP_OR, CPM_OP_XOR,
        CPM_OP_INC, CPM_OP_DEC, CPM_OP_LOAD, CPM_OP_JUMP} |=> $stable(c_r))
        else $error("carry changed by non-carry op");
    a_bit_copy: assert property (plain_op && EXEC_OP_I == CPM_OP_BIT_LOW |=>
        c_r == $past(EXEC_BIT_I) && taken_r == !$past(EXEC_BIT_I))
        else $error("bit test carry wrong");
    a_branch_rel: assert property (plain_op && EXEC_OP_I == CPM_OP_BR_ZS && z_r |=>
        pc_r == $past(pc_r) + {{6{$past(EXEC_OPND_I[7])}}, $past(EXEC_OPND_I)})
        else $error("relative branch target wrong");
    a_call_ret: assert property (EXEC_VALID_I && EXEC_OP_I inside {CPM_OP_CALL_ABS, CPM_OP_CALL_REL} |=>
        rtn_r == $past(pc_r))
        else $error("call did not save return address");
    a_return: assert property (EXEC_VALID_I && EXEC_OP_I == CPM_OP_RETURN |=> pc_r == $past(rtn_r))
        else $error("return did not restore counter");
    a_jump_load: assert property (EXEC_VALID_I && EXEC_OP_I == CPM_OP_JUMP |=>
        pc_r == $past(EXEC_TARGET_I) && TAKEN_O)
        else $error("jump target not loaded");
    a_xch_low: assert property (EXEC_VALID_I && EXEC_OP_I == CPM_OP_XCH_HI && EXEC_XCH_LO_I |=>
        acc_r == $past(rtn_r[7:0]) && rtn_r[7:0] == $past(acc_r))
        else $error("low exchange wrong");
    a_dbg_flags: assert property (dbg_flag_wr |=>
        z_r == $past(WB_DAT_I[`CPM_FLAG_Z_BIT]) && c_r == $past(WB_DAT_I[`CPM_FLAG_C_BIT]))
        else $error("debug flag write lost");
    a_carry_force: assert property (plain_op && EXEC_OP_I inside {CPM_OP_SETC, CPM_OP_CLRC} |=>
        c_r == ($past(EXEC_OP_I) == CPM_OP_SETC) && $stable(acc_r) && $stable(z_r))
        else $error("carry set or clear wrong");
    a_rotate_left: assert property (plain_op && EXEC_OP_I == CPM_OP_ROL |=>
        {c_r, acc_r} == {$past(acc_r), $past(c_r)})
        else $error("rotate through carry wrong");
    a_carry_branch: assert property (plain_op && EXEC_OP_I == CPM_OP_BR_CS |=> TAKEN_O == $past(c_r))
        else $error("carry branch decision wrong");
    a_direct_map: assert property (CORE_ADDR_I[13:8] == 6'h00 && CORE_ADDR_I[7:0] < `CPM_WIN_LO &&
        CORE_ADDR_I != 14'h000E |=> PHYS_ADDR_O == $past(CORE_ADDR_I))
        else $error("direct address not passed through");
    a_store_data: assert property (plain_op && EXEC_OP_I == CPM_OP_STORE |=>
        RESULT_O == $past(acc_r) && z_r == ($past(acc_r) == 8'h00))
        else $error("store data or zero flag wrong");
    a_fetch_step: assert property (FETCH_I && !EXEC_VALID_I |=> pc_r == $past(pc_r) + 14'h0001)
        else $error("fetch did not step counter");
    a_window_map: assert property (CORE_ADDR_I == 14'h000E |=> PHYS_ADDR_O == {6'h00, $past(idx_r)})
        else $error("data window not redirected");
    a_page_map: assert property (CORE_ADDR_I[13:6] == 8'h03 |=>
        PHYS_ADDR_O == {$past(page_r), $past(CORE_ADDR_I[5:0])})
        else $error("page window address wrong");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held for two cycles");

    c_add_overflow: cover property (plain_op && EXEC_OP_I == CPM_OP_ADD ##1 c_r);
    c_call_return: cover property (EXEC_VALID_I && EXEC_OP_I == CPM_OP_CALL_REL ##[1:20]
        EXEC_VALID_I && EXEC_OP_I == CPM_OP_RETURN);
    c_window_read: cover property (WB_CYC_I && WB_STB_I && !WB_WE_I && WB_ADR_I == 11'h038 ##1 WB_ACK_O);
    c_debug_flags: cover property (dbg_flag_wr ##1 z_r && c_r);
    c_page_window: cover property (CORE_ADDR_I[13:6] == 8'h03 ##1 PHYS_ADDR_O[13:6] != 8'h00);

endmodule // cpm_regs
`default_nettype wire
